// >>> src/bsp_status_pins.sv
// Sideband status pin logic with APB register access
//
// What this block does
// - No pending report: NAK interrupt requests
// - Pending report: return 16-bit report
// - Report layout: speed, power, input pins
// - Non-input pins report as zero
// - Media detect enable and polarity bits
// - No media: answer sense 3A/00
// - Media back: next query answers 28/00
// - Removable drive is always master, one only
// - Search bit clear skips startup drive search
// - Pin defaults from config, host may change
// - Awake indicator low, floats when suspended
// - Float bit: ATA pins float without VBUS
// - Sample VBUS at startup, then every 20 ms
// - Sampled VBUS low releases D+ pull-up
// - ATA pull-up follows ATA bus activity
// - ATA pull-up floats with other ATA pins
// - ATA pull-up pin usable as input
// - Full current granted unless suspended; small package grants only when bus powered
// - Power mode pin picks descriptor power
// - No mode pin: power from config value
// - Power mode sampled only at resets
// - Reset input low restores pin defaults at once
// - D+ pull-up needs VBUS and drive/media
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "bsp_consts.svh"
module bsp_status_pins #(
  parameter int unsigned POLL_CYCLES = `BSP_VBUS_POLL_MS * 1000 * `BSP_CLK_MHZ,
  parameter bit          HAS_MODE_PIN = 1'b1,  // Power mode input present
  parameter bit          PKG_SMALL    = 1'b0,  // Small package: grant bus powered only
  parameter int          GPIO_W       = 6
) (
  input  wire logic                  clock_i,
  input  wire logic                  nrst_i,
  // APB slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output var  logic [31:0]           prdata_o,
  output var  logic                  pready_o,
  output var  logic                  pslverr_o,
  // Interrupt endpoint
  input  wire logic                  ep1_request_i,
  output var  logic                  ep1_nak_o,
  output var  logic                  ep1_valid_o,
  output var  logic [15:0]           ep1_data_o,
  // Status query
  input  wire logic                  sense_query_i,
  output var  logic                  sense_valid_o,
  output var  bsp_pkg::bsp_sense_type sense_o,
  // Device state from the rest of the bridge
  input  wire logic                  high_speed_i,
  input  wire logic                  suspend_i,
  input  wire logic                  usb_reset_i,
  input  wire logic                  ata_active_i,
  input  wire logic                  drive_detected_i,
  // Pins
  input  wire logic                  vbus_present_input_i,
  input  wire logic                  removable_media_detect_i,
  input  wire logic                  bus_powered_select_i,
  input  wire logic [GPIO_W-1:0]     gpio_i,
  output var  logic [GPIO_W-1:0]     gpio_o,
  output var  logic [GPIO_W-1:0]     gpio_oe_o,
  input  wire logic                  ata_pullup_enable_i,
  output var  logic                  ata_pullup_enable_o,
  output var  logic                  ata_pullup_enable_oe_o,
  output var  logic                  ata_pins_oe_o,
  output var  logic                  dplus_pullup_o,
  output var  logic                  awake_indicator_n_o,
  output var  logic                  awake_indicator_n_oe_o,
  output var  logic                  full_current_grant_n_o,
  output var  logic                  full_current_grant_n_oe_o,
  output var  logic                  search_ata_o,
  output var  logic                  media_is_master_o,
  output var  bsp_pkg::bsp_desc_type desc_o
);
  import bsp_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]        cfg_reg;        // Configuration byte
  logic [GPIO_W-1:0] dir_reg;        // 1 = input
  logic [GPIO_W-1:0] out_reg;        // Output levels
  logic [7:0]        maxpwr_reg;     // Power value without mode pin
  logic [15:0]       sent_reg;       // Last report handed to host
  logic              media_reg;      // Media seen last cycle
  logic              changed_reg;    // Media came back, not yet reported
  logic              pwr_take_reg;   // Power mode sample due
  bsp_apb_state_type apb_reg;        // APB phase
  bsp_apb_state_type apb_next;
  logic              vbus_s;         // Polled VBUS level

  // ****************************************
  // VBUS poller
  // ****************************************
  bsp_vbus_poller #(
    .PERIOD (POLL_CYCLES)
  ) u_poll (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .level_i   (vbus_present_input_i),
    .sampled_o (vbus_s)
  );

  // ****************************************
  // Decoding
  // ****************************************
  wire logic              media_en  = cfg_reg[`BSP_CFG_MEDIA_EN];
  wire logic              media_pol = cfg_reg[`BSP_CFG_MEDIA_POL];
  wire logic              float_en  = cfg_reg[`BSP_CFG_ATA_FLOAT];
  wire logic              pue_gpi   = cfg_reg[`BSP_CFG_PUE_GPI];
  // Disabled detect means media always counts as present
  wire logic              media_now = !media_en ||
                                      (removable_media_detect_i == media_pol);
  // Float only without VBUS and with the feature on
  wire logic              ata_oe    = !(float_en && !vbus_s);
  wire logic [GPIO_W-1:0] gpi       = gpio_i & dir_reg;
  wire logic              gpi2      = pue_gpi ? ata_pullup_enable_i
                                              : gpi[`BSP_GPI_PUE_BIT];
  wire logic [15:0]       report    = rep_pack(high_speed_i, !desc_o.self_powered,
                                               gpi, gpi2);
  wire logic              pending   = (report != sent_reg);
  wire logic              ep1_take  = ep1_request_i && pending;
  wire logic              q_take    = sense_query_i;
  wire logic              media_back = media_now && !media_reg;
  wire logic              apb_do    = (apb_reg == BSP_DONE);
  wire logic              wr_do     = apb_do && pwrite_i;
  wire logic              mapped    = addr_ok(paddr_i);
  wire bsp_desc_type      desc_new  = desc_pick(bus_powered_select_i, maxpwr_reg);

  // Report word; pin bit 2 may come from the pull-up pin
  function automatic logic [15:0] rep_pack(input logic hs, input logic bp,
                                           input logic [GPIO_W-1:0] g,
                                           input logic g2);
    logic [15:0] r;
    r = 16'h0;
    r[`BSP_REP_HS] = hs;
    r[`BSP_REP_BP] = bp;
    r[GPIO_W-1:0] = g;
    r[`BSP_GPI_PUE_BIT] = g2;
    return r;
  endfunction

  // Known register offsets
  function automatic logic addr_ok(input logic [11:0] a);
    return (a == `BSP_OFS_CFG) || (a == `BSP_OFS_GPIO_DIR) ||
           (a == `BSP_OFS_GPIO_OUT) || (a == `BSP_OFS_MAXPWR) ||
           (a == `BSP_OFS_STATUS) || (a == `BSP_OFS_REPORT) ||
           (a == `BSP_OFS_DESC);
  endfunction

  // Descriptor power from mode pin or configured value
  function automatic bsp_desc_type desc_pick(input logic mode, input logic [7:0] mp);
    bsp_desc_type d;
    if (HAS_MODE_PIN)
    begin
      d.max_power    = mode ? `BSP_PWR_BUS : `BSP_PWR_SELF;
      d.self_powered = !mode;
    end
    else
    begin
      d.max_power    = mp;
      d.self_powered = (mp <= `BSP_PWR_SELF);
    end
    return d;
  endfunction

  // Read data mux
  logic [31:0] rdata;
  always_comb
  begin
    rdata = 32'h0;
    unique case (paddr_i)
      `BSP_OFS_CFG:      rdata = {24'h0, cfg_reg};
      `BSP_OFS_GPIO_DIR: rdata = 32'(dir_reg);
      `BSP_OFS_GPIO_OUT: rdata = 32'(out_reg);
      `BSP_OFS_MAXPWR:   rdata = {24'h0, maxpwr_reg};
      // Live state: VBUS, media, changed, pending, D+ pull-up
      `BSP_OFS_STATUS:   rdata = {27'h0, dplus_pullup_o, pending,
                                  changed_reg, media_now, vbus_s};
      `BSP_OFS_REPORT:   rdata = {16'h0, report};
      `BSP_OFS_DESC:     rdata = {23'h0, desc_o.self_powered, desc_o.max_power};
      default:           rdata = 32'h0;
    endcase
  end

  // ****************************************
  // APB slave
  // ****************************************
  // Two wait states: answer lands two edges after the access phase starts
  always_comb
  begin
    apb_next = apb_reg;
    unique case (apb_reg)
      BSP_IDLE: apb_next = (psel_i && penable_i) ? BSP_WAIT : BSP_IDLE;
      BSP_WAIT: apb_next = BSP_DONE;
      BSP_DONE: apb_next = BSP_IDLE;
    endcase
  end

  // Phase register and registered answer
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      apb_reg   <= BSP_IDLE;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end
    else
    begin
      apb_reg   <= apb_next;
      pready_o  <= (apb_next == BSP_DONE);
      pslverr_o <= (apb_next == BSP_DONE) && !mapped;
      prdata_o  <= (apb_next == BSP_DONE && !pwrite_i) ? rdata : 32'h0;
    end
  end

  // Writable registers; read-only and unmapped writes are dropped
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cfg_reg    <= `BSP_CFG_RST;
      dir_reg    <= GPIO_W'(`BSP_GPIO_DIR_RST);
      out_reg    <= GPIO_W'(`BSP_GPIO_OUT_RST);
      maxpwr_reg <= `BSP_MAXPWR_RST;
    end
    else if (wr_do)
    begin
      if (paddr_i == `BSP_OFS_CFG)
        cfg_reg <= pwdata_i[7:0];
      if (paddr_i == `BSP_OFS_GPIO_DIR)
        dir_reg <= pwdata_i[GPIO_W-1:0];
      if (paddr_i == `BSP_OFS_GPIO_OUT)
        out_reg <= pwdata_i[GPIO_W-1:0];
      if (paddr_i == `BSP_OFS_MAXPWR)
        maxpwr_reg <= pwdata_i[7:0];
    end
  end

  // ****************************************
  // Interrupt endpoint
  // ****************************************
  // Snapshot of the sent word; a change in the send cycle stays pending
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sent_reg    <= 16'h0;
      ep1_nak_o   <= 1'b0;
      ep1_valid_o <= 1'b0;
      ep1_data_o  <= 16'h0;
    end
    else
    begin
      ep1_nak_o   <= ep1_request_i && !pending;
      ep1_valid_o <= ep1_take;
      if (ep1_take)
      begin
        ep1_data_o <= report;
        sent_reg   <= report;
      end
    end
  end

  // ****************************************
  // Removable media sense
  // ****************************************
  // A media return in the query cycle wins over the clear
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      media_reg     <= 1'b1;
      changed_reg   <= 1'b0;
      sense_valid_o <= 1'b0;
      sense_o       <= '0;
    end
    else
    begin
      media_reg     <= media_now;
      sense_valid_o <= q_take;
      changed_reg   <= media_back || (changed_reg && !(q_take && media_now));
      if (q_take)
      begin
        if (!media_now)
          sense_o <= '{`BSP_ASC_NO_MEDIA, `BSP_ASCQ_ZERO};
        else if (changed_reg)
          sense_o <= '{`BSP_ASC_CHANGED, `BSP_ASCQ_ZERO};
        else
          sense_o <= '{`BSP_ASC_NONE, `BSP_ASCQ_ZERO};
      end
    end
  end

  // ****************************************
  // Descriptor power
  // ****************************************
  // Mode pin caught only after reset release or at a USB reset
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pwr_take_reg <= 1'b1;
      desc_o       <= '{`BSP_PWR_BUS, 1'b0};
    end
    else
    begin
      pwr_take_reg <= 1'b0;
      if (pwr_take_reg || usb_reset_i)
        desc_o <= desc_new;
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  // Reset holds every pin at its startup state
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      gpio_o                    <= '0;
      gpio_oe_o                 <= '0;
      ata_pullup_enable_o       <= 1'b0;
      ata_pullup_enable_oe_o    <= 1'b0;
      ata_pins_oe_o             <= 1'b0;
      dplus_pullup_o            <= 1'b0;
      awake_indicator_n_o       <= 1'b0;
      awake_indicator_n_oe_o    <= 1'b0;
      full_current_grant_n_o    <= 1'b1;
      full_current_grant_n_oe_o <= 1'b0;
      search_ata_o              <= 1'b0;
      media_is_master_o         <= 1'b1;
    end
    else
    begin
      gpio_o                 <= out_reg;
      gpio_oe_o              <= ~dir_reg;
      ata_pullup_enable_o    <= ata_active_i;
      ata_pullup_enable_oe_o <= ata_oe && !pue_gpi;
      ata_pins_oe_o          <= ata_oe;
      // Pull-up needs VBUS and a fixed drive or media detect on
      dplus_pullup_o         <= vbus_s && (drive_detected_i || media_en);
      awake_indicator_n_o    <= 1'b0;
      awake_indicator_n_oe_o <= !suspend_i;
      // Small package grants only when bus powered
      full_current_grant_n_o <= !(!suspend_i &&
                                 (!PKG_SMALL || !desc_o.self_powered));
      full_current_grant_n_oe_o <= 1'b1;
      search_ata_o           <= cfg_reg[`BSP_CFG_SEARCH];
      // Removable media is always device 0 on the ATA bus
      media_is_master_o      <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> src/bsp_consts.svh
// Offsets, field positions, reset values, codes and timing for the status pin block
`ifndef BSP_CONSTS_SVH
`define BSP_CONSTS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define BSP_OFS_CFG      12'h000
`define BSP_OFS_GPIO_DIR 12'h004
`define BSP_OFS_GPIO_OUT 12'h008
`define BSP_OFS_MAXPWR   12'h00c
`define BSP_OFS_STATUS   12'h010
`define BSP_OFS_REPORT   12'h014
`define BSP_OFS_DESC     12'h018
// ****************************************
// Configuration byte and report word fields
// ****************************************
`define BSP_CFG_MEDIA_EN  0
`define BSP_CFG_MEDIA_POL 1
`define BSP_CFG_ATA_FLOAT 4
`define BSP_CFG_SEARCH    6
`define BSP_CFG_PUE_GPI   7
`define BSP_GPI_PUE_BIT   2
`define BSP_REP_HS        9
`define BSP_REP_BP        8
// ****************************************
// Reset values
// ****************************************
`define BSP_CFG_RST      8'h40
`define BSP_GPIO_DIR_RST 6'h3f
`define BSP_GPIO_OUT_RST 6'h00
`define BSP_MAXPWR_RST   8'hfa
// ****************************************
// Sense codes and descriptor power values
// ****************************************
`define BSP_ASC_NO_MEDIA 8'h3a
`define BSP_ASC_CHANGED  8'h28
`define BSP_ASC_NONE     8'h00
`define BSP_ASCQ_ZERO    8'h00
`define BSP_PWR_BUS      8'hfa
`define BSP_PWR_SELF     8'h01
// ****************************************
// Timing
// ****************************************
`define BSP_CLK_MHZ      200
`define BSP_VBUS_POLL_MS 20
`define BSP_RESET_MS     10
`endif

// >>> src/bsp_pkg.sv
// Types shared by the status pin block
package bsp_pkg;
  // Sense answer for a status query
  typedef struct packed
  {
    logic [7:0] asc;
    logic [7:0] ascq;
  } bsp_sense_type;
  // Descriptor power values
  typedef struct packed
  {
    logic [7:0] max_power;
    logic       self_powered;
  } bsp_desc_type;
  // APB slave phases
  typedef enum logic [1:0] {BSP_IDLE, BSP_WAIT, BSP_DONE} bsp_apb_state_type;
endpackage

// >>> src/bsp_vbus_poller.sv
// Periodic sampler of the VBUS-present input
`timescale 1ns/10ps
`default_nettype none
module bsp_vbus_poller #(
  parameter int unsigned PERIOD = 4000000
) (
  input  wire logic clock_i,
  input  wire logic nrst_i,
  input  wire logic level_i,
  output var  logic sampled_o
);
  // ****************************************
  // Poll timer
  // ****************************************
  logic [31:0] count_reg;   // Cycles since last sample
  logic        first_reg;   // Startup sample still due
  logic        take;        // Sample strobe

  // First sample right after reset, then once per period
  assign take = first_reg || (count_reg == 32'(PERIOD - 1));

  // Timer and sample register
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      count_reg <= 32'h0;
      first_reg <= 1'b1;
      sampled_o <= 1'b0;
    end
    else
    begin
      first_reg <= 1'b0;
      count_reg <= take ? 32'h0 : count_reg + 32'h1;
      if (take)
        sampled_o <= level_i;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/bsp_status_pins_sva.sv
// Concurrent checks on the status pin block ports
`timescale 1ns/10ps
`default_nettype none
module bsp_status_pins_chk #(
  parameter int unsigned POLL_CYCLES = 50,
  parameter int          GPIO_W      = 6
) (
  input wire logic              clock_i,
  input wire logic              nrst_i,
  input wire logic              ep1_request_i,
  input wire logic              ep1_nak_o,
  input wire logic              ep1_valid_o,
  input wire logic [15:0]       ep1_data_o,
  input wire logic              sense_query_i,
  input wire logic              sense_valid_o,
  input wire logic              suspend_i,
  input wire logic              ata_active_i,
  input wire logic              vbus_present_input_i,
  input wire logic [GPIO_W-1:0] gpio_oe_o,
  input wire logic              ata_pullup_enable_o,
  input wire logic              ata_pullup_enable_oe_o,
  input wire logic              ata_pins_oe_o,
  input wire logic              dplus_pullup_o,
  input wire logic              awake_indicator_n_o,
  input wire logic              awake_indicator_n_oe_o,
  input wire logic              full_current_grant_n_o,
  input wire logic              media_is_master_o
);
  // ****
  // Helper: cycles VBUS has stayed low
  // ****
  logic [15:0] lo_cnt_reg;  // Saturates, so a long outage cannot wrap
  // Counter cleared whenever VBUS is seen present
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      lo_cnt_reg <= 16'h0000;
    else if (vbus_present_input_i)
      lo_cnt_reg <= 16'h0000;
    else if (lo_cnt_reg != 16'hffff)
      lo_cnt_reg <= lo_cnt_reg + 16'h0001;
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  // ****
  // Assertions
  // ****
  a_one_answer: assert property (ep1_request_i |=> ep1_nak_o != ep1_valid_o)
    else $error("Interrupt request not answered by one pulse");
  a_report_resv: assert property (ep1_valid_o |->
    ep1_data_o[15:10] == 6'h00 && ep1_data_o[7:6] == 2'h0)
    else $error("Reserved report bits set");
  a_report_dir: assert property (ep1_valid_o |->
    (ep1_data_o[GPIO_W-1:0] & $past(gpio_oe_o)) == '0)
    else $error("Output pin reported nonzero");
  a_awake_low: assert property (awake_indicator_n_o == 1'b0)
    else $error("Awake indicator driven high");
  a_awake_float: assert property (suspend_i |=> !awake_indicator_n_oe_o)
    else $error("Awake indicator driven in suspend");
  a_dplus_vbus: assert property (
    lo_cnt_reg > POLL_CYCLES + 3 |-> !dplus_pullup_o)
    else $error("D+ pull-up held without VBUS");
  a_sense_answer: assert property (sense_query_i |=> sense_valid_o)
    else $error("Status query not answered");
  a_master_fixed: assert property (media_is_master_o)
    else $error("Removable drive not master");
  a_pue_float: assert property (!ata_pins_oe_o |-> !ata_pullup_enable_oe_o)
    else $error("ATA pull-up driven while ATA pins float");
  a_pue_level: assert property (ata_pullup_enable_oe_o |->
    ata_pullup_enable_o == $past(ata_active_i))
    else $error("ATA pull-up does not follow bus activity");
  a_full_suspend: assert property (suspend_i |=> full_current_grant_n_o)
    else $error("Full current granted in suspend");
  a_reset_pins: assert property (disable iff (1'b0) !nrst_i |->
    gpio_oe_o == '0 && !ata_pins_oe_o && full_current_grant_n_o)
    else $error("Pins not at defaults during reset");
endmodule
bind bsp_status_pins bsp_status_pins_chk #(.POLL_CYCLES(POLL_CYCLES), .GPIO_W(GPIO_W)) u_chk (
  .clock_i, .nrst_i, .ep1_request_i, .ep1_nak_o, .ep1_valid_o, .ep1_data_o,
  .sense_query_i, .sense_valid_o, .suspend_i, .ata_active_i, .vbus_present_input_i,
  .gpio_oe_o, .ata_pullup_enable_o, .ata_pullup_enable_oe_o, .ata_pins_oe_o,
  .dplus_pullup_o, .awake_indicator_n_o, .awake_indicator_n_oe_o,
  .full_current_grant_n_o, .media_is_master_o);
`default_nettype wire

// >>> testbench/bsp_host_model.sv
// Host model issuing interrupt polls and status queries
`timescale 1ns/10ps
`default_nettype none
module bsp_host_model (
  input  wire logic clock_i,
  input  wire logic nrst_i,
  input  wire logic poll_i,         // Ask the interrupt endpoint
  input  wire logic query_i,        // Ask for sense data
  output var  logic ep1_request_o,  // One-cycle token
  output var  logic sense_query_o   // One-cycle token
);
  // Requests launched just after an edge, one cycle long
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ep1_request_o <= 1'b0;  // Silent while reset is held
      sense_query_o <= 1'b0;
    end
    else
    begin
      ep1_request_o <= poll_i;
      sense_query_o <= query_i;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/bsp_status_pins_test.sv
// Self-checking bench for the status pin block
`timescale 1ns/10ps
`default_nettype none
module test_bsp_status_pins;
  import bsp_pkg::*;
  localparam int POLL = 50;  // Short poll keeps the run brief
  // ****
  // Signals
  // ****
  logic          clock_i = 1'b0, nrst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
  logic          pwrite_i = 1'b0, pready_o, pslverr_o, ep1_request_i, ep1_nak_o;
  logic [11:0]   paddr_i = 12'h000;
  logic [31:0]   pwdata_i = 32'h0, prdata_o, q;
  logic [15:0]   ep1_data_o;
  logic          ep1_valid_o, sense_query_i, sense_valid_o, e;
  bsp_sense_type sense_o;
  bsp_desc_type  desc_o;
  logic          high_speed_i = 1'b1, suspend_i = 1'b0, usb_reset_i = 1'b0;
  logic          ata_active_i = 1'b0, drive_detected_i = 1'b1, vbus_present_input_i = 1'b1;
  logic          removable_media_detect_i = 1'b1, bus_powered_select_i = 1'b1;
  logic [5:0]    gpio_i, gpio_o, gpio_oe_o, gpio_drv = 6'h2d;
  logic          ata_pullup_enable_i, ata_pullup_enable_o, ata_pullup_enable_oe_o;
  logic          ata_pins_oe_o, dplus_pullup_o, awake_indicator_n_o, awake_indicator_n_oe_o;
  logic          full_current_grant_n_o, full_current_grant_n_oe_o, search_ata_o;
  logic          media_is_master_o, pue_drv = 1'b0, poll = 1'b0, query = 1'b0;
  int            bad_count = 0, num_checks = 0;
  // Pin levels resolved from every driver
  assign gpio_i = (gpio_oe_o & gpio_o) | (~gpio_oe_o & gpio_drv);
  assign ata_pullup_enable_i = ata_pullup_enable_oe_o ? ata_pullup_enable_o : pue_drv;
  always #2.5 clock_i = ~clock_i;
  bsp_status_pins #(.POLL_CYCLES(POLL)) u_dut (.clock_i, .nrst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ep1_request_i,
    .ep1_nak_o, .ep1_valid_o, .ep1_data_o, .sense_query_i, .sense_valid_o, .sense_o,
    .high_speed_i, .suspend_i, .usb_reset_i, .ata_active_i, .drive_detected_i,
    .vbus_present_input_i, .removable_media_detect_i, .bus_powered_select_i, .gpio_i,
    .gpio_o, .gpio_oe_o, .ata_pullup_enable_i, .ata_pullup_enable_o,
    .ata_pullup_enable_oe_o, .ata_pins_oe_o, .dplus_pullup_o, .awake_indicator_n_o,
    .awake_indicator_n_oe_o, .full_current_grant_n_o, .full_current_grant_n_oe_o,
    .search_ata_o, .media_is_master_o, .desc_o);
  bsp_host_model u_host (.clock_i, .nrst_i, .poll_i(poll), .query_i(query),
    .ep1_request_o(ep1_request_i), .sense_query_o(sense_query_i));
  // ****
  // Shared tasks
  // ****
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic hang(input string what);
    bad_count++;
    $display("FAIL %s timeout", what);
    finish_test();
  endtask
  // APB cycle; request held until pready seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20)
      hang("apb");
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    tick(2);  // Let the write reach the pins
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("apb read", exp, q);
  endtask
  // One host request, then wait for its answer pulse
  task automatic ask(input logic s);
    int n;
    @(posedge clock_i);
    if (s)
      query <= 1'b1;
    else
      poll <= 1'b1;
    @(posedge clock_i);
    query <= 1'b0;
    poll <= 1'b0;
    for (n = 0; n < 10; n++)
    begin
      @(posedge clock_i);
      #1;
      if (ep1_valid_o === 1'b1 || ep1_nak_o === 1'b1 || sense_valid_o === 1'b1)
        break;
    end
    if (n == 10)
      hang("answer");
  endtask
  task automatic ep(input logic v, input logic [15:0] d);
    ask(1'b0);
    chk("ep1 valid", v, ep1_valid_o);
    chk("ep1 nak", !v, ep1_nak_o);
    if (v)
      chk("ep1 data", d, ep1_data_o);
  endtask
  task automatic sq(input logic [15:0] d);
    ask(1'b1);
    chk("sense", d, sense_o);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    rd(12'h000, 32'h40);
    rd(12'h004, 32'h3f);
    rd(12'h008, 32'h00);
    rd(12'h00c, 32'hfa);
    rd(12'h01c, 32'h00);
    chk("slverr", 1, e);
    wr(12'h00c, 32'h55);
    rd(12'h00c, 32'h55);
    wr(12'h008, 32'h05);
  endtask
  task automatic t_report();
    ep(1'b1, 16'h032d);
    ep(1'b0, 16'h0000);
    rd(12'h014, 32'h032d);
    wr(12'h004, 32'h30);
    chk("gpio oe", 6'h0f, gpio_oe_o);
    chk("gpio out", 6'h05, gpio_o);
    ep(1'b1, 16'h0320);
    wr(12'h004, 32'h3f);
    wr(12'h000, 32'hc0);
    gpio_drv <= 6'h29;
    pue_drv <= 1'b1;
    tick(3);
    chk("pullup oe", 0, ata_pullup_enable_oe_o);
    ep(1'b1, 16'h032d);
    wr(12'h000, 32'h40);
  endtask
  task automatic t_media();
    wr(12'h000, 32'h43);
    removable_media_detect_i <= 1'b0;
    sq(16'h3a00);
    removable_media_detect_i <= 1'b1;
    sq(16'h2800);
    sq(16'h0000);
    wr(12'h000, 32'h01);
    sq(16'h3a00);
    chk("search", 0, search_ata_o);
    chk("master", 1, media_is_master_o);
  endtask
  task automatic t_vbus();
    wr(12'h000, 32'h50);
    vbus_present_input_i <= 1'b0;
    tick(POLL + 10);
    chk("dplus", 0, dplus_pullup_o);
    chk("ata oe", 0, ata_pins_oe_o);
    chk("pullup oe", 0, ata_pullup_enable_oe_o);
    wr(12'h000, 32'h40);
    chk("ata oe", 1, ata_pins_oe_o);
    ata_active_i <= 1'b1;
    vbus_present_input_i <= 1'b1;
    tick(POLL + 10);
    chk("dplus", 1, dplus_pullup_o);
    chk("pullup", 1, ata_pullup_enable_o);
    drive_detected_i <= 1'b0;
    tick(3);
    chk("dplus", 0, dplus_pullup_o);
  endtask
  task automatic t_power();
    chk("desc", 9'h1f4, desc_o);
    bus_powered_select_i <= 1'b0;
    tick(3);
    chk("desc", 9'h1f4, desc_o);
    usb_reset_i <= 1'b1;
    tick(1);
    usb_reset_i <= 1'b0;
    tick(3);
    chk("desc", 9'h003, desc_o);
    rd(12'h018, 32'h101);
    suspend_i <= 1'b1;
    tick(3);
    chk("awake oe", 0, awake_indicator_n_oe_o);
    chk("grant", 1, full_current_grant_n_o);
    suspend_i <= 1'b0;
    tick(3);
    chk("awake oe", 1, awake_indicator_n_oe_o);
    chk("grant", 0, full_current_grant_n_o);
  endtask
  // Reset held 10 cycles, then every scenario in turn
  initial
  begin
    nrst_i <= 1'b0;  // Falling edge at time zero resets every flop
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_regs();
    t_report();
    t_media();
    t_vbus();
    t_power();
    finish_test();
  end
endmodule
`default_nettype wire
